/* File: padb_regs.vh */
// Address map constants for the physical address decoder
`ifndef PADB_REGS_VH
`define PADB_REGS_VH

// ============================================================
// Region codes (address bits 23:21)
`define PADB_REG_MAPPED      3'h0
`define PADB_REG_BOOT_ROM    3'h1
`define PADB_REG_SECOND_ROM  3'h2
`define PADB_REG_UART        3'h3
`define PADB_REG_TIMER       3'h4
`define PADB_REG_MAP_A       3'h5
`define PADB_REG_MAP_C       3'h6
`define PADB_REG_CONTEXT     3'h7

// ============================================================
// Peripheral register addresses, boot exit address and fixed reset values
`define PADB_SERIAL_CHANNEL_A_DATA    24'h600000
`define PADB_SERIAL_CHANNEL_A_COMMAND 24'h600002
`define PADB_SERIAL_CHANNEL_B_DATA    24'h600004
`define PADB_SERIAL_CHANNEL_B_COMMAND 24'h600006
`define PADB_TIMER_DATA_PORT          24'h800000
`define PADB_TIMER_COMMAND_PORT       24'h800002
`define PADB_BOOT_EXIT_ADDR           24'hE00000
`define PADB_ADDR_ZERO                24'h000000
`define PADB_IRQ_NONE                 3'h0

// ============================================================
// Field positions and sizes
`define PADB_REGION_HI       23
`define PADB_REGION_LO       21
`define PADB_PAGE_LO         11
`define PADB_OFFSET_HI       20
`define PADB_TIMER_SEL_BIT   1
`define PADB_RAM_LIMIT       24'h080000
`define PADB_MB_IO_BASE      24'h1F0000
`define PADB_MB_MEM_BASE     24'h100000
`define PADB_UART_SEL_HI     2
`define PADB_UART_SEL_LO     1

`endif

/* File: padb_decoder.v */
// Physical address decoder with boot-state redirection
`include "padb_regs.vh"

// Operation
// - Top three address bits pick one of eight 2-Mbyte regions; lowest is mapped.
// - 200000-3FFFFF selects boot ROM bank, except writes on second variant; 400000-5FFFFF selects second ROM bank.
// - 600000 region selects dual UART; A data/cmd 0/2, B data/cmd 4/6.
// - 800000 region selects timer; data at 800000, command at 800002.
// - A00000 region: page map on second variant, process id on first.
// - C00000 region: segment map on second variant, page map on first.
// - E00000 region selects context register on second variant.
// - Mapped space reaches RAM below 512K, or Multibus memory or I/O.
// - Map translates in 2-Kbyte page units.
// - Boot state from reset; reads and fetches in mapped space come from ROM.
// - Writes in mapped space during boot state still go through the map to RAM or Multibus.
// - Boot state blocks all interrupts, including the non-maskable level.
// - Exit write: E00000 on first variant, boot ROM region on second.
module padb_decoder #(
    parameter SECOND_GEN = 1
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    input  wire [23:0] bus_addr,
    input  wire        bus_strobe,
    input  wire        bus_write,
    input  wire [2:0]  irq_level_in,
    input  wire [23:0] map_phys_addr,
    output reg  [23:0] target_addr,
    output wire        sel_ram,
    output wire        sel_boot_rom_bank,
    output wire        sel_second_rom_bank,
    output wire        sel_uart,
    output wire [1:0]  uart_reg_sel,
    output wire        sel_timer,
    output wire        timer_reg_sel,
    output wire        sel_page_map,
    output wire        sel_segment_map,
    output wire        sel_process_id_register,
    output wire        sel_context,
    output wire        sel_multibus_mem,
    output wire        sel_multibus_io,
    output wire [12:0] map_page_index,
    output reg  [2:0]  irq_level_out,
    output reg         boot_state
);

    // ============================================================
    // Region decode
    wire [2:0] region;
    wire       in_mapped;
    wire       is_gen2;
    wire       redirect;
    wire       exit_match;
    wire       exit_hit;

    assign region    = bus_addr[`PADB_REGION_HI:`PADB_REGION_LO];
    assign in_mapped = (region == `PADB_REG_MAPPED);
    assign is_gen2   = (SECOND_GEN != 0);
    assign redirect  = in_mapped && boot_state && !bus_write;

    // ============================================================
    // Page index handed to the map
    assign map_page_index = {3'h0, bus_addr[`PADB_OFFSET_HI:`PADB_PAGE_LO]};

    // ============================================================
    // Boot exit detection
    assign exit_match = is_gen2 ? (region == `PADB_REG_BOOT_ROM) : (bus_addr == `PADB_BOOT_EXIT_ADDR);
    assign exit_hit   = bus_strobe && bus_write && exit_match;

    // ============================================================
    // Next select values
    reg [23:0] next_target_addr;
    reg        next_ram;
    reg        next_boot_rom;
    reg        next_second_rom;
    reg        next_uart;
    reg        next_timer;
    reg        next_page_map;
    reg        next_segment_map;
    reg        next_process_id;
    reg        next_context;
    reg        next_mb_mem;
    reg        next_mb_io;
    wire [1:0] next_uart_reg;
    wire       next_timer_reg;

    always @* begin
        next_target_addr = bus_addr;
        next_ram         = 1'b0;
        next_boot_rom    = 1'b0;
        next_second_rom  = 1'b0;
        next_uart        = 1'b0;
        next_timer       = 1'b0;
        next_page_map    = 1'b0;
        next_segment_map = 1'b0;
        next_process_id  = 1'b0;
        next_context     = 1'b0;
        next_mb_mem      = 1'b0;
        next_mb_io       = 1'b0;
        if (bus_strobe) begin
            case (region)
                `PADB_REG_MAPPED: begin
                    if (redirect) begin
                        next_boot_rom    = 1'b1;
                        next_target_addr = {`PADB_REG_BOOT_ROM, bus_addr[`PADB_OFFSET_HI:0]};
                    end else if (map_phys_addr >= `PADB_MB_IO_BASE) begin
                        next_mb_io       = 1'b1;
                        next_target_addr = map_phys_addr - `PADB_MB_IO_BASE;
                    end else if (map_phys_addr >= `PADB_MB_MEM_BASE) begin
                        next_mb_mem      = 1'b1;
                        next_target_addr = map_phys_addr - `PADB_MB_MEM_BASE;
                    end else begin
                        next_ram         = (map_phys_addr < `PADB_RAM_LIMIT);
                        next_target_addr = map_phys_addr;
                    end
                end
                `PADB_REG_BOOT_ROM: begin
                    next_boot_rom = !(bus_write && is_gen2);
                end
                `PADB_REG_SECOND_ROM: begin
                    next_second_rom = 1'b1;
                end
                `PADB_REG_UART: begin
                    next_uart = 1'b1;
                end
                `PADB_REG_TIMER: begin
                    next_timer = 1'b1;
                end
                `PADB_REG_MAP_A: begin
                    next_page_map   = is_gen2;
                    next_process_id = !is_gen2;
                end
                `PADB_REG_MAP_C: begin
                    next_segment_map = is_gen2;
                    next_page_map    = !is_gen2;
                end
                `PADB_REG_CONTEXT: begin
                    next_context = is_gen2;
                end
                default: begin
                    next_ram = 1'b0;
                end
            endcase
        end
    end

    // ============================================================
    // Register selects within the peripherals
    assign next_uart_reg  = bus_addr[`PADB_UART_SEL_HI:`PADB_UART_SEL_LO];
    assign next_timer_reg = bus_addr[`PADB_TIMER_SEL_BIT];

    // ============================================================
    // Registered select outputs
    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_ram_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_ram),
        .value      (sel_ram)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_boot_rom_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_boot_rom),
        .value      (sel_boot_rom_bank)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_second_rom_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_second_rom),
        .value      (sel_second_rom_bank)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_uart_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_uart),
        .value      (sel_uart)
    );

    padb_sel_flop #(.WIDTH(2)) padb_sel_flop_uart_reg_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_uart_reg),
        .value      (uart_reg_sel)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_timer_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_timer),
        .value      (sel_timer)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_timer_reg_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_timer_reg),
        .value      (timer_reg_sel)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_page_map_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_page_map),
        .value      (sel_page_map)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_segment_map_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_segment_map),
        .value      (sel_segment_map)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_process_id_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_process_id),
        .value      (sel_process_id_register)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_context_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_context),
        .value      (sel_context)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_mb_mem_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_mb_mem),
        .value      (sel_multibus_mem)
    );

    padb_sel_flop #(.WIDTH(1)) padb_sel_flop_mb_io_i (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .next_value (next_mb_io),
        .value      (sel_multibus_io)
    );

    // ============================================================
    // Target address
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_addr <= `PADB_ADDR_ZERO;
        end else if (clk_en) begin
            target_addr <= next_target_addr;
        end
    end

    // ============================================================
    // Boot state flag
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_state <= 1'b1;
        end else if (clk_en) begin
            if (exit_hit) begin
                boot_state <= 1'b0;
            end
        end
    end

    // ============================================================
    // Interrupt gate
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_level_out <= `PADB_IRQ_NONE;
        end else if (clk_en) begin
            if (boot_state && !exit_hit) begin
                irq_level_out <= `PADB_IRQ_NONE;
            end else begin
                irq_level_out <= irq_level_in;
            end
        end
    end

endmodule // padb_decoder

// ============================================================
// One registered select with clock enable
module padb_sel_flop #(
    parameter WIDTH = 1
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire             clk_en,
    input  wire [WIDTH-1:0] next_value,
    output reg  [WIDTH-1:0] value
);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            value <= next_value;
        end
    end

endmodule // padb_sel_flop

/* File: padb_decoder_props.sv */
// Assertions on the decoder ports
module padb_decoder_props (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        bus_strobe,
    input wire logic        bus_write,
    input wire logic        boot_state,
    input wire logic        timer_reg_sel,
    input wire logic        sel_uart,
    input wire logic        sel_timer,
    input wire logic        sel_second_rom_bank,
    input wire logic        sel_boot_rom_bank,
    input wire logic        sel_context,
    input wire logic [23:0] bus_addr,
    input wire logic [23:0] target_addr,
    input wire logic [2:0]  irq_level_in,
    input wire logic [2:0]  irq_level_out,
    input wire logic [1:0]  uart_reg_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire       t  = bus_strobe & clk_en;
    wire [2:0] rg = bus_addr[23:21];
    property p_uart; t && rg == 3'h3 |=> sel_uart && uart_reg_sel == $past(bus_addr[2:1]); endproperty
    a_uart: assert property (p_uart) else $error("uart select wrong");
    property p_timer; t && rg == 3'h4 |=> sel_timer && timer_reg_sel == $past(bus_addr[1]); endproperty
    a_timer: assert property (p_timer) else $error("timer select wrong");
    property p_rom2; t && rg == 3'h2 |=> sel_second_rom_bank; endproperty
    a_rom2: assert property (p_rom2) else $error("second rom select wrong");
    property p_ctx; t && rg == 3'h7 |=> sel_context; endproperty
    a_ctx: assert property (p_ctx) else $error("context select wrong");
    property p_idle; clk_en && !bus_strobe |=> !(sel_uart | sel_timer | sel_context); endproperty
    a_idle: assert property (p_idle) else $error("select without strobe");
    property p_redir; t && boot_state && !bus_write && rg == 3'h0 |=>
        sel_boot_rom_bank && target_addr == {3'h1, $past(bus_addr[20:0])}; endproperty
    a_redir: assert property (p_redir) else $error("boot read not redirected");
    property p_irq; boot_state |-> irq_level_out == 3'h0; endproperty
    a_irq: assert property (p_irq) else $error("interrupt passed in boot");
    property p_exit; t && bus_write && rg == 3'h1 |=> !boot_state; endproperty
    a_exit: assert property (p_exit) else $error("boot not left");
    property p_sticky; !boot_state |=> !boot_state; endproperty
    a_sticky: assert property (p_sticky) else $error("boot set again");
    property p_irq_pass; clk_en && !boot_state |=> irq_level_out == $past(irq_level_in); endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("interrupt not passed after boot");
endmodule // padb_decoder_props
bind padb_decoder padb_decoder_props padb_decoder_props_i (.sys_clk, .rst_n, .clk_en, .bus_strobe,
    .bus_write, .boot_state, .timer_reg_sel, .sel_uart, .sel_timer, .sel_second_rom_bank,
    .sel_boot_rom_bank, .sel_context, .bus_addr, .target_addr, .irq_level_in, .irq_level_out, .uart_reg_sel);

/* File: padb_core_model.sv */
// Core model driving the decoder bus
module padb_core_model (
    input wire logic         sys_clk,
    output logic      [23:0] bus_addr,
    output logic             bus_strobe,
    output logic             bus_write,
    output wire logic [23:0] map_phys_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    assign map_phys_addr = bus_addr;
    initial begin
        bus_addr = 24'h000000;
        bus_strobe = 1'b0;
        bus_write = 1'b0;
    end
    task automatic access(input logic [23:0] a, input logic w);
        @(posedge sys_clk);
        {bus_addr, bus_strobe, bus_write} <= {a, 1'b1, w};
        @(posedge sys_clk);
        {bus_addr, bus_strobe, bus_write} <= {~a, 1'b0, ~w};
    endtask
endmodule // padb_core_model

/* File: test_padb_decoder.sv */
// Self-checking bench for the decoder
module test_padb_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, bus_strobe, bus_write, boot_state, timer_reg_sel;
    logic sel_ram, sel_boot_rom_bank, sel_second_rom_bank, sel_uart, sel_timer, sel_page_map;
    logic sel_segment_map, sel_process_id_register, sel_context, sel_multibus_mem, sel_multibus_io;
    logic [23:0] bus_addr, map_phys_addr, target_addr, r;
    logic [12:0] map_page_index;
    logic [2:0]  irq_level_in = 3'h0, irq_level_out, irq_prev;
    logic [1:0]  uart_reg_sel;
    logic [37:0] notes[$];
    int          fail_count = 0, comparisons = 0;
    wire  [10:0] sels = {sel_ram, sel_boot_rom_bank, sel_second_rom_bank, sel_uart, sel_timer, sel_page_map,
        sel_segment_map, sel_process_id_register, sel_context, sel_multibus_mem, sel_multibus_io};
    padb_decoder padb_decoder_i (.sys_clk, .rst_n, .clk_en, .bus_addr, .bus_strobe, .bus_write, .irq_level_in,
        .map_phys_addr, .target_addr, .sel_ram, .sel_boot_rom_bank, .sel_second_rom_bank, .sel_uart,
        .uart_reg_sel, .sel_timer, .timer_reg_sel, .sel_page_map, .sel_segment_map, .sel_process_id_register,
        .sel_context, .sel_multibus_mem, .sel_multibus_io, .map_page_index, .irq_level_out, .boot_state);
    padb_core_model padb_core_model_i (.sys_clk, .bus_addr, .bus_strobe, .bus_write, .map_phys_addr);
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) irq_level_in <= 3'($urandom);
    always @(posedge sys_clk) irq_prev <= irq_level_in;
    task automatic chk(input logic [37:0] act, input logic [37:0] exp);
        comparisons++;
        if (act !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, act, exp);
        end
    endtask
    task go(input logic [23:0] a, input logic w, input logic [10:0] s, input logic [23:0] t);
        if (s != 11'h000) notes.push_back({s, s[7] ? a[2:1] : 2'h0, s[6] & a[1], t});
        padb_core_model_i.access(a, w);
        $display("test %h done", a);
    endtask
    always @(posedge sys_clk) begin
        #1;
        if (|sels) chk({sels, sels[7] ? uart_reg_sel : 2'h0, sels[6] & timer_reg_sel,
            |(sels & 11'h603) ? target_addr : 24'h0}, notes.pop_front());
    end
    task finish_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        finish_test;
    end
    initial begin
        void'($urandom(18387));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        r = $urandom & 24'h1FFFFE;
        go(r, 1'b0, 11'h200, {3'h1, r[20:0]});
        #1 chk(38'(irq_level_out), 38'h0);
        go(24'h000200, 1'b1, 11'h400, 24'h000200);
        for (int i = 0; i < 8; i += 2) go(24'h600000 + i, i[1], 11'h080, 24'h0);
        go(24'h800000, 1'b1, 11'h040, 24'h0);
        go(24'h800002, 1'b0, 11'h040, 24'h0);
        go(24'h400000, 1'b0, 11'h100, 24'h0);
        go(24'hA00000, 1'b0, 11'h020, 24'h0);
        go(24'hC00000, 1'b0, 11'h010, 24'h0);
        go(24'h200000, 1'b1, 11'h000, 24'h0);
        #1 chk(38'(boot_state), 38'h0);
        chk(38'(irq_level_out), 38'(irq_prev));
        go(r & 24'h07FFFE, 1'b0, 11'h400, r & 24'h07FFFE);
        go(24'h080000, 1'b0, 11'h000, 24'h0);
        go(24'h100010, 1'b1, 11'h002, 24'h000010);
        #1 chk(38'(map_page_index), 38'(bus_addr[20:11]));
        go(24'h1F0020, 1'b0, 11'h001, 24'h000020);
        go(24'hE00000, 1'b1, 11'h004, 24'h0);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 chk(38'(boot_state), 38'h1);
        clk_en <= 1'b0;
        go(24'h200000, 1'b1, 11'h000, 24'h0);
        #1 chk(38'(boot_state), 38'h1);
        clk_en <= 1'b1;
        @(posedge sys_clk);
        #2 chk(38'(notes.size()), 38'h0);
        finish_test;
    end
endmodule // test_padb_decoder
